// ==== pkg/rscl_pkg.sv ====
// rscl_pkg: constants for the reset strap configuration latch
// assumes one 100 MHz clock and a classic 32-bit wishbone register port
package rscl_pkg;
    // clocking
    localparam int unsigned RSCL_CLK_HZ = 100_000_000;
    localparam int unsigned RSCL_MII_CLK_HZ = 25_000_000;
    localparam int unsigned RSCL_MII_HALF_CYC = RSCL_CLK_HZ / (2 * RSCL_MII_CLK_HZ);
    localparam int unsigned RSCL_DIV_W = 4;

    // strap vector bit positions
    localparam int unsigned RSCL_ST_P5_FC = 0;
    localparam int unsigned RSCL_ST_P5_BP = 1;
    localparam int unsigned RSCL_ST_P5_CD = 2;
    localparam int unsigned RSCL_ST_P5_BO = 3;
    localparam int unsigned RSCL_ST_P5_FS = 4;
    localparam int unsigned RSCL_ST_P4_DUP = 5;
    localparam int unsigned RSCL_ST_P4_FFC = 6;
    localparam int unsigned RSCL_ST_SW_FC = 7;
    localparam int unsigned RSCL_ST_SW_DUP = 8;
    localparam int unsigned RSCL_ST_W = 9;

    // frame size limits in bytes
    localparam logic [10:0] RSCL_LEN_TAGGED = 11'd1522;
    localparam logic [10:0] RSCL_LEN_UNTAGGED = 11'd1518;
    localparam logic [10:0] RSCL_LEN_HUGE = 11'd1536;

    // register byte offsets
    localparam logic [7:0] RSCL_REG_STRAP = 8'h00;
    localparam logic [7:0] RSCL_REG_CTRL = 8'h04;
    localparam logic [7:0] RSCL_REG_PINSTAT = 8'h08;

    // control register fields and reset value
    localparam int unsigned RSCL_CTRL_SW_PHY = 0;
    localparam int unsigned RSCL_CTRL_P5_EN = 1;
    localparam int unsigned RSCL_CTRL_W = 2;
    localparam logic [1:0] RSCL_CTRL_RST = 2'h3;

    // pin status register fields
    localparam int unsigned RSCL_PS_DRIVE = 0;
    localparam int unsigned RSCL_PS_SWTXC = 1;
    localparam int unsigned RSCL_PS_SWRXC = 2;
    localparam int unsigned RSCL_PS_MIICLK = 3;

    // drive phase of the dual-role pins
    typedef enum logic [1:0] {
        RSCL_PH_RESET = 2'b00,
        RSCL_PH_DRIVE = 2'b01
    } rscl_phase_e;
endpackage : rscl_pkg

// ==== rtl/rscl_sync2.sv ====
// rscl_sync2: two flip-flop synchroniser for a vector of pin levels
// assumes each bit is an independent level from outside the clock domain
`timescale 1ns/1ps
module rscl_sync2 #(
    parameter int unsigned W = 1
) (
    // clock
    input wire logic clk_i,
    // asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta;
    logic [W-1:0] stable;

    // no reset: the stages only carry pin levels and settle in two edges
    always_ff @(posedge clk_i) begin
        meta <= d_i;
        stable <= meta;
    end

    assign q_o = stable;
endmodule : rscl_sync2

// ==== rtl/rscl_top.sv ====
// rscl_top: strap sampling during reset, latched configuration and the
// later output role of the same mii pins, plus a wishbone register port
// assumes rst_i is held for at least three clock edges with straps stable
//
// Operation
// - strap pins are pulled-down inputs in reset, driven outputs afterwards
// - p5 rx bit 3 low enables flow control, high disables it
// - p5 rx bit 2 low disables back pressure, high enables it
// - p5 rx bit 1 low drops excessive collision frames, high keeps them
// - p5 rx bit 0 high enables aggressive half-duplex back-off
// - p5 rx error low limits to 1522/1518 bytes, high allows 1536
// - p5 carrier sense selects port 4 fallback duplex, high is full
// - p5 collision high forces flow control on port 4
// - switch mii clocks are inputs in mac mode, driven in phy mode
// - switch rx bit 3 high enables switch mii full-duplex flow control
// - switch rx bit 2 low gives full duplex, high gives half duplex
// - with port 5 mii enabled the p5 rx clock is driven toward the mac
`timescale 1ns/1ps
module rscl_top
    import rscl_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,

    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,

    // port 5 dual-role pins: strap inputs in reset, mii outputs afterwards
    input wire logic p5_rx_valid_i,
    input wire logic p5_rx_bit3_flowctl_strap_i,
    input wire logic p5_rx_bit2_backpressure_strap_i,
    input wire logic p5_rx_bit1_colldrop_strap_i,
    input wire logic p5_rx_bit0_backoff_strap_i,
    input wire logic p5_rx_err_framesize_strap_i,
    input wire logic p5_carrier_duplex_strap_i,
    input wire logic p5_collision_forcefc_strap_i,
    output logic p5_rx_valid_o,
    output logic [3:0] p5_rx_data_o,
    output logic p5_rx_err_o,
    output logic p5_carrier_o,
    output logic p5_collision_o,
    output logic p5_pins_oe_n_o,
    output logic p5_pins_pulldown_o,

    // port 5 receive clock, output only
    output logic p5_rx_clock_o,
    output logic p5_rx_clock_oe_n_o,

    // switch mii dual-role pins
    input wire logic sw_rx_valid_i,
    input wire logic sw_rx_bit3_fc_strap_i,
    input wire logic sw_rx_bit2_duplex_strap_i,
    output logic sw_rx_valid_o,
    output logic [3:2] sw_rx_data_o,
    output logic sw_pins_oe_n_o,
    output logic sw_pins_pulldown_o,

    // switch mii clock pins, two-way
    input wire logic sw_tx_clock_i,
    input wire logic sw_rx_clock_i,
    output logic sw_tx_clock_o,
    output logic sw_rx_clock_o,
    output logic sw_clocks_oe_n_o,

    // switch fabric side data for the pins after reset
    input wire logic fab_p5_rx_valid_i,
    input wire logic [3:0] fab_p5_rx_data_i,
    input wire logic fab_p5_rx_err_i,
    input wire logic fab_p5_carrier_i,
    input wire logic fab_p5_collision_i,
    input wire logic fab_sw_rx_valid_i,
    input wire logic [3:2] fab_sw_rx_data_i,

    // latched configuration toward the switch core
    output logic cfg_flowctl_en_o,
    output logic cfg_backpressure_en_o,
    output logic cfg_colldrop_en_o,
    output logic cfg_backoff_aggr_o,
    output logic [10:0] cfg_max_tagged_len_o,
    output logic [10:0] cfg_max_untagged_len_o,
    output logic cfg_p4_full_duplex_o,
    output logic cfg_p4_force_fc_o,
    output logic cfg_sw_fc_en_o,
    output logic cfg_sw_half_duplex_o,
    output logic cfg_sw_phy_mode_o
);
    // synchronised pin levels
    logic [RSCL_ST_W-1:0] strap_raw;
    logic [RSCL_ST_W-1:0] strap_sync;
    logic [1:0] swclk_sync;

    assign strap_raw[RSCL_ST_P5_FC] = p5_rx_bit3_flowctl_strap_i;
    assign strap_raw[RSCL_ST_P5_BP] = p5_rx_bit2_backpressure_strap_i;
    assign strap_raw[RSCL_ST_P5_CD] = p5_rx_bit1_colldrop_strap_i;
    assign strap_raw[RSCL_ST_P5_BO] = p5_rx_bit0_backoff_strap_i;
    assign strap_raw[RSCL_ST_P5_FS] = p5_rx_err_framesize_strap_i;
    assign strap_raw[RSCL_ST_P4_DUP] = p5_carrier_duplex_strap_i;
    assign strap_raw[RSCL_ST_P4_FFC] = p5_collision_forcefc_strap_i;
    assign strap_raw[RSCL_ST_SW_FC] = sw_rx_bit3_fc_strap_i;
    assign strap_raw[RSCL_ST_SW_DUP] = sw_rx_bit2_duplex_strap_i;

    rscl_sync2 #(
        .W(RSCL_ST_W)
    ) u_strap_sync (
        .clk_i(clk_i),
        .d_i(strap_raw),
        .q_o(strap_sync)
    );

    // clock levels seen on the switch mii clock pins, for status only
    rscl_sync2 #(
        .W(2)
    ) u_swclk_sync (
        .clk_i(clk_i),
        .d_i({sw_rx_clock_i, sw_tx_clock_i}),
        .q_o(swclk_sync)
    );

    // strap latch and drive phase
    logic [RSCL_ST_W-1:0] strap;
    logic [RSCL_ST_W-1:0] next_strap;
    rscl_phase_e phase;
    rscl_phase_e next_phase;

    always_comb begin
        next_strap = strap;
        next_phase = phase;
        case (phase)
            RSCL_PH_RESET: begin
                // keep following the pins while reset lasts; the last sample
                // before release is the one that stays
                if (rst_i) begin
                    next_strap = strap_sync;
                end else begin
                    next_phase = RSCL_PH_DRIVE;
                end
            end
            RSCL_PH_DRIVE: begin
                if (rst_i) begin
                    next_phase = RSCL_PH_RESET;
                    next_strap = strap_sync;
                end
            end
            default: begin
                next_phase = RSCL_PH_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        strap <= next_strap;
        phase <= next_phase;
    end

    // configuration decode from the latched straps
    always_comb begin
        cfg_flowctl_en_o = ~strap[RSCL_ST_P5_FC];
        cfg_backpressure_en_o = strap[RSCL_ST_P5_BP];
        cfg_colldrop_en_o = ~strap[RSCL_ST_P5_CD];
        cfg_backoff_aggr_o = strap[RSCL_ST_P5_BO];
        cfg_p4_full_duplex_o = strap[RSCL_ST_P4_DUP];
        cfg_p4_force_fc_o = strap[RSCL_ST_P4_FFC];
        cfg_sw_fc_en_o = strap[RSCL_ST_SW_FC];
        cfg_sw_half_duplex_o = strap[RSCL_ST_SW_DUP];
        if (strap[RSCL_ST_P5_FS]) begin
            cfg_max_tagged_len_o = RSCL_LEN_HUGE;
            cfg_max_untagged_len_o = RSCL_LEN_HUGE;
        end else begin
            cfg_max_tagged_len_o = RSCL_LEN_TAGGED;
            cfg_max_untagged_len_o = RSCL_LEN_UNTAGGED;
        end
    end

    // control register: switch mii role and port 5 mii enable
    logic [RSCL_CTRL_W-1:0] ctrl;
    logic [RSCL_CTRL_W-1:0] next_ctrl;
    logic wb_hit;
    logic wb_ack;
    logic next_wb_ack;
    logic [31:0] wb_dat;
    logic [31:0] next_wb_dat;
    logic [31:0] rd_word;
    logic mii_clk;

    // answers one cycle after the request; the ack term blocks a repeat
    // response while the master still holds the strobe
    assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack;

    always_comb begin
        rd_word = 32'h0;
        case (wb_adr_i)
            RSCL_REG_STRAP: rd_word[RSCL_ST_W-1:0] = strap;
            RSCL_REG_CTRL: rd_word[RSCL_CTRL_W-1:0] = ctrl;
            RSCL_REG_PINSTAT: begin
                rd_word[RSCL_PS_DRIVE] = (phase == RSCL_PH_DRIVE);
                rd_word[RSCL_PS_SWTXC] = swclk_sync[0];
                rd_word[RSCL_PS_SWRXC] = swclk_sync[1];
                rd_word[RSCL_PS_MIICLK] = mii_clk;
            end
            default: rd_word = 32'h0;
        endcase
    end

    always_comb begin
        next_ctrl = ctrl;
        next_wb_ack = wb_hit;
        next_wb_dat = wb_dat;
        if (wb_hit) begin
            next_wb_dat = wb_we_i ? 32'h0 : rd_word;
            if (wb_we_i && wb_sel_i[0] && wb_adr_i == RSCL_REG_CTRL) begin
                next_ctrl = wb_dat_i[RSCL_CTRL_W-1:0];
            end
        end
        if (rst_i) begin
            next_ctrl = RSCL_CTRL_RST;
            next_wb_ack = 1'b0;
            next_wb_dat = 32'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        ctrl <= next_ctrl;
        wb_ack <= next_wb_ack;
        wb_dat <= next_wb_dat;
    end

    assign wb_ack_o = wb_ack;
    assign wb_dat_o = wb_dat;
    assign cfg_sw_phy_mode_o = ctrl[RSCL_CTRL_SW_PHY];

    // mii clock: a half-period enable from a divider toggles the clock level
    logic [RSCL_DIV_W-1:0] div_cnt;
    logic [RSCL_DIV_W-1:0] next_div_cnt;
    logic half_tick;
    logic next_mii_clk;

    assign half_tick = (div_cnt == RSCL_DIV_W'(RSCL_MII_HALF_CYC - 1));

    always_comb begin
        next_div_cnt = half_tick ? '0 : div_cnt + 1'b1;
        next_mii_clk = half_tick ? ~mii_clk : mii_clk;
        if (rst_i) begin
            next_div_cnt = '0;
            next_mii_clk = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        div_cnt <= next_div_cnt;
        mii_clk <= next_mii_clk;
    end

    // pin output stage; data outputs held low until the drive phase
    logic drive;
    logic [10:0] pin_q;
    logic [10:0] next_pin_q;

    assign drive = (phase == RSCL_PH_DRIVE);

    always_comb begin
        next_pin_q = 11'h0;
        if (drive) begin
            next_pin_q = {fab_sw_rx_data_i, fab_sw_rx_valid_i, fab_p5_collision_i,
                fab_p5_carrier_i, fab_p5_rx_err_i, fab_p5_rx_data_i, fab_p5_rx_valid_i};
        end
        if (rst_i) begin
            next_pin_q = 11'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        pin_q <= next_pin_q;
    end

    assign p5_rx_valid_o = pin_q[0];
    assign p5_rx_data_o = pin_q[4:1];
    assign p5_rx_err_o = pin_q[5];
    assign p5_carrier_o = pin_q[6];
    assign p5_collision_o = pin_q[7];
    assign sw_rx_valid_o = pin_q[8];
    assign sw_rx_data_o = pin_q[10:9];

    // inputs with pull-down in reset, driven once released; a disabled
    // port 5 mii stays released so the board may leave it floating
    always_comb begin
        p5_pins_oe_n_o = ~(drive & ctrl[RSCL_CTRL_P5_EN]);
        p5_pins_pulldown_o = ~drive;
        sw_pins_oe_n_o = ~drive;
        sw_pins_pulldown_o = ~drive;
    end

    // the board must have let go of the straps once oe_n falls
    always_comb begin
        sw_tx_clock_o = mii_clk;
        sw_rx_clock_o = mii_clk;
        sw_clocks_oe_n_o = ~(drive & ctrl[RSCL_CTRL_SW_PHY]);
        p5_rx_clock_o = mii_clk;
        p5_rx_clock_oe_n_o = ~(drive & ctrl[RSCL_CTRL_P5_EN]);
    end
endmodule : rscl_top

// ==== test/rscl_board_model.sv ====
// rscl_board_model: strap resistors and external mac on the dual-role pins
// assumes the device's output enables are low while it drives
`timescale 1ns/1ps
module rscl_board_model (
    // resistor levels chosen by the bench
    input wire logic [8:0] lvl_i,
    // device drive
    input wire logic p5_oe_n_i, sw_oe_n_i, clk_oe_n_i,
    input wire logic [8:0] dev_i,
    input wire logic [1:0] dev_clk_i,
    // levels at the pins
    output logic [8:0] pin_o,
    output logic [1:0] clk_o
);
    logic mclk = 1'b0;
    // free-running mac clock, unrelated in phase to the device clock
    always #20 mclk = ~mclk;
    // resistors only win while the device lets go of the pin
    assign pin_o[6:0] = p5_oe_n_i ? lvl_i[6:0] : dev_i[6:0];
    assign pin_o[8:7] = sw_oe_n_i ? lvl_i[8:7] : dev_i[8:7];
    assign clk_o = clk_oe_n_i ? {2{mclk}} : dev_clk_i;
endmodule : rscl_board_model

// ==== test/rscl_top_sva.sv ====
// rscl_top_chk: concurrent checks on the strap latch ports
// assumes it is bound into rscl_top and sees its ports by name
`timescale 1ns/1ps
module rscl_top_chk
    import rscl_pkg::*;
(
    // clock and reset
    input wire logic clk_i, rst_i,
    // strap pins
    input wire logic p5_rx_bit3_flowctl_strap_i, p5_rx_bit2_backpressure_strap_i,
    input wire logic p5_rx_bit1_colldrop_strap_i, p5_rx_bit0_backoff_strap_i,
    input wire logic p5_rx_err_framesize_strap_i, p5_carrier_duplex_strap_i,
    input wire logic p5_collision_forcefc_strap_i, sw_rx_bit3_fc_strap_i,
    input wire logic sw_rx_bit2_duplex_strap_i,
    // pin roles
    input wire logic p5_pins_oe_n_o, p5_pins_pulldown_o, sw_pins_oe_n_o, sw_pins_pulldown_o,
    input wire logic p5_rx_clock_o, p5_rx_clock_oe_n_o, sw_clocks_oe_n_o,
    input wire logic sw_tx_clock_o, sw_rx_clock_o,
    input wire logic [3:0] fab_p5_rx_data_i, p5_rx_data_o,
    // configuration
    input wire logic cfg_flowctl_en_o, cfg_backpressure_en_o, cfg_colldrop_en_o,
    input wire logic cfg_backoff_aggr_o, cfg_p4_full_duplex_o, cfg_p4_force_fc_o,
    input wire logic cfg_sw_fc_en_o, cfg_sw_half_duplex_o, cfg_sw_phy_mode_o,
    input wire logic [10:0] cfg_max_tagged_len_o, cfg_max_untagged_len_o
);
    wire logic [8:0] pins = {sw_rx_bit2_duplex_strap_i, sw_rx_bit3_fc_strap_i,
        p5_collision_forcefc_strap_i, p5_carrier_duplex_strap_i, p5_rx_err_framesize_strap_i,
        p5_rx_bit0_backoff_strap_i, p5_rx_bit1_colldrop_strap_i,
        p5_rx_bit2_backpressure_strap_i, p5_rx_bit3_flowctl_strap_i};
    wire logic [29:0] cfgv = {cfg_flowctl_en_o, cfg_backpressure_en_o, cfg_colldrop_en_o,
        cfg_backoff_aggr_o, cfg_p4_full_duplex_o, cfg_p4_force_fc_o, cfg_sw_fc_en_o,
        cfg_sw_half_duplex_o, cfg_max_tagged_len_o, cfg_max_untagged_len_o};
    wire logic [29:0] ev = {~pins[0], pins[1], ~pins[2], pins[3], pins[5], pins[6], pins[7],
        pins[8], pins[4] ? {RSCL_LEN_HUGE, RSCL_LEN_HUGE} : {RSCL_LEN_TAGGED, RSCL_LEN_UNTAGGED}};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // four steady edges cover both sync stages and the latch
    sequence s_held;
        (rst_i && $stable(pins))[*4];
    endsequence
    a_p5_map: assert property (disable iff (1'b0)
        s_held |-> cfgv[29:26] == ev[29:26] && cfgv[21:0] == ev[21:0])
        else $error("port 5 strap decode wrong");
    a_p4_map: assert property (disable iff (1'b0) s_held |-> cfgv[25:24] == ev[25:24])
        else $error("port 4 strap decode wrong");
    a_sw_map: assert property (disable iff (1'b0) s_held |-> cfgv[23:22] == ev[23:22])
        else $error("switch mii strap decode wrong");
    a_reset_role: assert property (disable iff (1'b0) rst_i |=>
        p5_pins_oe_n_o && sw_pins_oe_n_o && p5_pins_pulldown_o && sw_pins_pulldown_o)
        else $error("pins not released with pull-down in reset");
    a_drive_after: assert property ($fell(rst_i) |=>
        !sw_pins_oe_n_o && !sw_pins_pulldown_o && !p5_pins_pulldown_o)
        else $error("pins not driven after reset");
    a_cfg_hold: assert property (!$past(rst_i) |-> $stable(cfgv))
        else $error("latched settings changed after reset");
    a_clk_reset: assert property (disable iff (1'b0)
        sw_pins_oe_n_o |-> sw_clocks_oe_n_o && p5_rx_clock_oe_n_o)
        else $error("clock driven while pins released");
    a_mac_inputs: assert property ((!cfg_sw_phy_mode_o)[*2] |-> sw_clocks_oe_n_o)
        else $error("switch clocks driven in mac mode");
    a_p5_clock: assert property (!p5_rx_clock_oe_n_o && $rose(p5_rx_clock_o) |=>
        p5_rx_clock_o ##1 (!p5_rx_clock_o)[*2] ##1 p5_rx_clock_o)
        else $error("port 5 receive clock shape wrong");
    a_sw_clock: assert property (!sw_clocks_oe_n_o && $rose(sw_tx_clock_o) |=>
        (sw_tx_clock_o && sw_rx_clock_o) ##1 (!(sw_tx_clock_o || sw_rx_clock_o))[*2]
        ##1 sw_tx_clock_o)
        else $error("switch mii clock shape wrong in phy mode");
    a_pin_follow: assert property (!p5_pins_oe_n_o && !$past(p5_pins_oe_n_o) |->
        p5_rx_data_o == $past(fab_p5_rx_data_i))
        else $error("port 5 pin data not one cycle behind");
    c_release: cover property ($fell(rst_i));
    c_mac_mode: cover property (!cfg_sw_phy_mode_o && !sw_pins_oe_n_o);
    c_huge: cover property (!rst_i && pins[4]);
endmodule : rscl_top_chk

bind rscl_top rscl_top_chk u_chk (.*);

// ==== test/testbench.sv ====
// testbench: strap latch bench, board model on the strap pins
// assumes wishbone answers come within a few cycles
`timescale 1ns/1ps
module testbench
    import rscl_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic p5_rx_valid_o, p5_rx_err_o, p5_carrier_o, p5_collision_o, p5_pins_oe_n_o;
    logic p5_pins_pulldown_o, p5_rx_clock_o, p5_rx_clock_oe_n_o, sw_rx_valid_o;
    logic sw_pins_oe_n_o, sw_pins_pulldown_o, sw_tx_clock_o, sw_rx_clock_o, sw_clocks_oe_n_o;
    logic [3:0] p5_rx_data_o;
    logic [3:2] sw_rx_data_o;
    logic fab_p5_rx_valid_i = 1'b0, fab_p5_rx_err_i = 1'b0, fab_p5_carrier_i = 1'b0;
    logic fab_p5_collision_i = 1'b0, fab_sw_rx_valid_i = 1'b0;
    logic [3:0] fab_p5_rx_data_i = 4'h0;
    logic [3:2] fab_sw_rx_data_i = 2'h0;
    logic cfg_flowctl_en_o, cfg_backpressure_en_o, cfg_colldrop_en_o, cfg_backoff_aggr_o;
    logic cfg_p4_full_duplex_o, cfg_p4_force_fc_o, cfg_sw_fc_en_o, cfg_sw_half_duplex_o;
    logic cfg_sw_phy_mode_o;
    logic [10:0] cfg_max_tagged_len_o, cfg_max_untagged_len_o;
    logic [8:0] lvl = 9'h000, pin;
    logic [1:0] mclk;
    logic [8:0] sv [4] = '{9'h000, 9'h1ff, 9'h0aa, 9'h155};
    int error_cnt = 0, checked = 0;
    wire logic [29:0] cfgv = {cfg_flowctl_en_o, cfg_backpressure_en_o, cfg_colldrop_en_o,
        cfg_backoff_aggr_o, cfg_p4_full_duplex_o, cfg_p4_force_fc_o, cfg_sw_fc_en_o,
        cfg_sw_half_duplex_o, cfg_max_tagged_len_o, cfg_max_untagged_len_o};

    always #5 clk_i = ~clk_i;

    rscl_top DUT (.*, .p5_rx_valid_i(p5_rx_valid_o), .sw_rx_valid_i(sw_rx_valid_o),
        .p5_rx_bit3_flowctl_strap_i(pin[0]), .p5_rx_bit2_backpressure_strap_i(pin[1]),
        .p5_rx_bit1_colldrop_strap_i(pin[2]), .p5_rx_bit0_backoff_strap_i(pin[3]),
        .p5_rx_err_framesize_strap_i(pin[4]), .p5_carrier_duplex_strap_i(pin[5]),
        .p5_collision_forcefc_strap_i(pin[6]), .sw_rx_bit3_fc_strap_i(pin[7]),
        .sw_rx_bit2_duplex_strap_i(pin[8]), .sw_tx_clock_i(mclk[0]), .sw_rx_clock_i(mclk[1]));
    rscl_board_model board (.lvl_i(lvl), .p5_oe_n_i(p5_pins_oe_n_o), .sw_oe_n_i(sw_pins_oe_n_o),
        .clk_oe_n_i(sw_clocks_oe_n_o), .dev_i({sw_rx_data_o[2], sw_rx_data_o[3], p5_collision_o,
        p5_carrier_o, p5_rx_err_o, p5_rx_data_o[0], p5_rx_data_o[1], p5_rx_data_o[2],
        p5_rx_data_o[3]}), .dev_clk_i({sw_rx_clock_o, sw_tx_clock_o}), .pin_o(pin), .clk_o(mclk));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [29:0] exp_cfg(input logic [8:0] l);
        return {~l[0], l[1], ~l[2], l[3], l[5], l[6], l[7], l[8],
            l[4] ? {RSCL_LEN_HUGE, RSCL_LEN_HUGE} : {RSCL_LEN_TAGGED, RSCL_LEN_UNTAGGED}};
    endfunction : exp_cfg

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, input logic [3:0] s = 4'hf);
        int n;
        n = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'b11, we, s, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        if (n >= 50) chk(32'h1, 32'h0);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask : wb

    task automatic t_reset(input logic [8:0] l);
        lvl <= l;
        rst_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        chk({p5_pins_oe_n_o, sw_pins_oe_n_o, p5_pins_pulldown_o, sw_pins_pulldown_o}, 4'hf);
        chk(cfgv, exp_cfg(l));
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({p5_pins_oe_n_o, sw_pins_oe_n_o, p5_pins_pulldown_o, sw_pins_pulldown_o}, 4'h0);
        wb(1'b0, RSCL_REG_STRAP, 32'h0, rd);
        chk(rd, {23'h0, l});
    endtask : t_reset

    // p5 released so new resistor levels really reach the strap inputs
    task automatic t_hold;
        t_reset(9'h0aa);
        wb(1'b1, RSCL_REG_CTRL, 32'h0, rd);
        lvl <= 9'h155;
        repeat (6) @(posedge clk_i);
        chk(cfgv, exp_cfg(9'h0aa));
        chk({p5_pins_oe_n_o, p5_rx_clock_oe_n_o, sw_clocks_oe_n_o}, 3'h7);
        // the strap register is read-only: a write must not disturb the latch
        wb(1'b1, RSCL_REG_STRAP, 32'h1ff, rd);
        wb(1'b0, RSCL_REG_STRAP, 32'h0, rd);
        chk(rd, 32'h0aa);
        wb(1'b1, RSCL_REG_CTRL, 32'h3, rd);
        // byte 0 disabled, so this write is dropped
        wb(1'b1, RSCL_REG_CTRL, 32'h0, rd, 4'he);
        wb(1'b0, RSCL_REG_CTRL, 32'h0, rd);
        chk(rd, 32'h3);
        chk({p5_pins_oe_n_o, p5_rx_clock_oe_n_o, sw_clocks_oe_n_o, cfg_sw_phy_mode_o}, 4'h1);
        wb(1'b0, RSCL_REG_PINSTAT, 32'h0, rd);
        chk({rd[31:4], rd[0]}, 29'h1);
        wb(1'b0, 8'h0c, 32'h0, rd);
        chk(rd, 32'h0);
    endtask : t_hold

    task automatic t_data;
        {fab_p5_rx_valid_i, fab_p5_rx_data_i, fab_p5_rx_err_i, fab_p5_carrier_i,
            fab_p5_collision_i, fab_sw_rx_valid_i, fab_sw_rx_data_i} <= 11'h5a9;
        repeat (3) @(posedge clk_i);
        chk({p5_rx_valid_o, p5_rx_data_o, p5_rx_err_o, p5_carrier_o, p5_collision_o,
            sw_rx_valid_o, sw_rx_data_o}, 11'h5a9);
    endtask : t_data

    task automatic conclude;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    initial begin
        foreach (sv[i]) t_reset(sv[i]);
        t_hold();
        t_data();
        conclude();
    end

    initial begin
        #50us;
        error_cnt++;
        conclude();
    end
endmodule : testbench
